//--- hdl/lasc_scan.sv
/*
  scan sequencer of a self-scanning linear photodiode array.
  assumes an external generator drives phase clocks, start, gate and
  scan done enable; light arrives as one intensity input for the element at light index.
*/
`timescale 1ns/1ns
module lasc_scan
  import lasc_pkg::*;
#(
  parameter int unsigned ELEMENTS = LASC_ELEMENTS,
  parameter int unsigned ACC_W    = LASC_ACC_W,
  parameter int unsigned IDX_W    = $clog2(ELEMENTS)
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             phase_one,
  input  wire logic             phase_two,
  input  wire logic             scan_start,
  input  wire logic             overflow_gate,
  input  wire logic             scan_done_enable,
  input  wire logic             voltage_sense,
  input  wire logic [7:0]       light_level,
  output logic      [IDX_W-1:0] light_index,
  output logic      [ACC_W-1:0] video_sample,
  output logic      [IDX_W-1:0] video_index,
  output logic                  video_valid,
  output logic                  line_reset,
  output logic                  scan_done_pulse,
  output logic                  integrating
);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(ELEMENTS - 1);
  localparam logic [ACC_W-1:0] ACC_MAX  = '1;

  logic [4:0] pins_s;
  logic       p1_s;
  logic       p2_s;
  logic       start_s;
  logic       gate_s;
  logic       done_en_s;

  lasc_sync #(.WIDTH(5)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({phase_one, phase_two, scan_start, overflow_gate,
                scan_done_enable}),
    .sync_out (pins_s)
  );
  assign {p1_s, p2_s, start_s, gate_s, done_en_s} = pins_s;

  lasc_state_t      state;
  lasc_state_t      next_state;
  logic             p1_q;
  logic             p2_q;
  logic             start_seen;
  logic             next_start_seen;
  logic [IDX_W-1:0] idx;
  logic [IDX_W-1:0] next_idx;
  logic [1:0]       tail_cnt;
  logic [1:0]       next_tail_cnt;
  logic [ACC_W-1:0] charge [ELEMENTS];
  logic [ACC_W-1:0] next_charge [ELEMENTS];
  logic [IDX_W-1:0] next_light_index;
  logic [ACC_W-1:0] next_video_sample;
  logic [IDX_W-1:0] next_video_index;
  logic             next_video_valid;
  logic             next_line_reset;
  logic             next_scan_done_pulse;
  logic             next_integrating;
  logic             p1_fall;
  logic             p2_rise;
  logic             read_now;
  logic             next_p1_q;
  logic             next_p2_q;

  function automatic logic [ACC_W-1:0] add_sat(input logic [ACC_W-1:0] a,
                                               input logic [7:0] b);
    logic [ACC_W:0] s;
    s = {1'b0, a} + {{(ACC_W-7){1'b0}}, b};
    add_sat = s[ACC_W] ? ACC_MAX : s[ACC_W-1:0];
  endfunction

  // element select shared by the read clear and the light sweep
  function automatic logic elem_hit(input logic [IDX_W-1:0] sel,
                                    input int unsigned      g);
    elem_hit = (sel == IDX_W'(g));
  endfunction

  assign p1_fall  = p1_q && !p1_s;
  assign p2_rise  = !p2_q && p2_s;
  assign read_now = p2_rise && (state == LASC_SCAN);

  // elements integrate one at a time, cycling the light index; a
  // trade for area against a per-element parallel light input
  generate
    for (genvar g = 0; g < ELEMENTS; g++) begin : g_cell
      always_comb begin
        next_charge[g] = charge[g];
        if (gate_s) begin
          next_charge[g] = '0;
        end else if (read_now && elem_hit(idx, g)) begin
          next_charge[g] = '0;
        end else if (elem_hit(light_index, g)) begin
          next_charge[g] = add_sat(charge[g], light_level);
        end
      end
    end
  endgenerate

  // edge history and light sweep run every clock, scanning or not;
  // edge registers reset low like the idle phase-two pin, so no
  // false rise follows reset
  always_comb begin
    next_p1_q        = p1_s;
    next_p2_q        = p2_s;
    next_light_index = (light_index == LAST_IDX) ? '0 : light_index + 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p1_q        <= 1'b0;
      p2_q        <= 1'b0;
      light_index <= '0;
    end else begin
      p1_q        <= next_p1_q;
      p2_q        <= next_p2_q;
      light_index <= next_light_index;
    end
  end

  always_comb begin
    next_state           = state;
    next_start_seen      = start_seen;
    next_idx             = idx;
    next_tail_cnt        = tail_cnt;
    next_video_sample    = video_sample;
    next_video_index     = video_index;
    next_video_valid     = 1'b0;
    next_line_reset      = 1'b0;
    next_scan_done_pulse = 1'b0;
    next_integrating     = !gate_s;
    if (start_s) begin
      next_start_seen = 1'b1;
    end
    // start loaded on phase one fall
    if (p1_fall && start_seen) begin
      next_start_seen = 1'b0;
      next_state      = LASC_SCAN;
      next_idx        = '0;
    end else begin
      if (p1_fall) begin
        next_start_seen = start_s;
      end
      unique case (state)
        LASC_IDLE: begin
        end
        LASC_SCAN: begin
          if (p2_rise) begin
            next_video_sample = charge[idx];
            next_video_index  = idx;
            next_video_valid  = 1'b1;
            next_line_reset   = voltage_sense;
            if (idx == LAST_IDX) begin
              next_state    = LASC_TAIL;
              next_tail_cnt = '0;
            end else begin
              next_idx = idx + 1'b1;
            end
          end
        end
        LASC_TAIL: begin
          if (p2_rise) begin
            next_tail_cnt = tail_cnt + 1'b1;
            if (tail_cnt == 2'(LASC_DONE_LAG - 1)) begin
              next_scan_done_pulse = done_en_s;
              next_state           = LASC_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state           <= LASC_IDLE;
      start_seen      <= 1'b0;
      idx             <= '0;
      tail_cnt        <= '0;
      video_sample    <= '0;
      video_index     <= '0;
      video_valid     <= 1'b0;
      line_reset      <= 1'b0;
      scan_done_pulse <= 1'b0;
      integrating     <= 1'b0;
      for (int i = 0; i < ELEMENTS; i++) begin
        charge[i] <= '0;
      end
    end else begin
      state           <= next_state;
      start_seen      <= next_start_seen;
      idx             <= next_idx;
      tail_cnt        <= next_tail_cnt;
      video_sample    <= next_video_sample;
      video_index     <= next_video_index;
      video_valid     <= next_video_valid;
      line_reset      <= next_line_reset;
      scan_done_pulse <= next_scan_done_pulse;
      integrating     <= next_integrating;
      for (int i = 0; i < ELEMENTS; i++) begin
        charge[i] <= next_charge[i];
      end
    end
  end
endmodule

//--- hdl/lasc_pkg.sv
/*
  constants and types for the linear array scan timing block.
  assumes one system clock; phase clocks and start arrive as pins.
*/
package lasc_pkg;
  localparam int unsigned LASC_ELEMENTS     = 256;
  localparam int unsigned LASC_DONE_LAG     = 2;
  localparam int unsigned LASC_ACC_W        = 16;
  localparam int unsigned LASC_START_MIN_NS = 10;
  localparam int unsigned LASC_CLK_NS       = 4;
  localparam int unsigned LASC_START_MIN_CYC =
    (LASC_START_MIN_NS + LASC_CLK_NS - 1) / LASC_CLK_NS;
  typedef enum logic [1:0] {
    LASC_IDLE,
    LASC_SCAN,
    LASC_TAIL
  } lasc_state_t;
endpackage

//--- hdl/lasc_sync.sv
/*
  two-flop synchroniser for a vector of pin inputs.
  assumes inputs are asynchronous to clk.
*/
`timescale 1ns/1ns
module lasc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_meta     = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync_out;
    end
  end
endmodule

//--- bench/lasc_scan_assertions.sv
/* port checker for lasc_scan, bound below.
   assumes phase clocks slower than clk/6. */
`timescale 1ns/1ns
module lasc_scan_chk #(
  parameter int unsigned N     = 8,
  parameter int unsigned IDX_W = 3,
  parameter int unsigned ACC_W = 16
) (
  input wire logic             clk,
  input wire logic             reset_n,
  input wire logic             phase_two,
  input wire logic             scan_start,
  input wire logic             overflow_gate,
  input wire logic             scan_done_enable,
  input wire logic             voltage_sense,
  input wire logic [IDX_W-1:0] video_index,
  input wire logic [ACC_W-1:0] video_sample,
  input wire logic             video_valid,
  input wire logic             line_reset,
  input wire logic             scan_done_pulse,
  input wire logic             integrating
);
  logic [IDX_W-1:0] last;
  logic [1:0]       rises;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // pin rises since the last read, saturating so it cannot wrap
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last  <= '0;
      rises <= '0;
    end else if (video_valid) begin
      last  <= video_index;
      rises <= '0;
    end else if ($rose(phase_two) && rises != 2'h3) begin
      rises <= rises + 2'h1;
    end
  end
  AST_READ_RISE: assert property (
    video_valid |-> $past(phase_two, 2)) else $error("read off phase two");
  AST_ORDER: assert property (
    video_valid && video_index != '0 |-> video_index == last + 1'b1)
    else $error("read out of order");
  AST_START: assert property (
    $rose(scan_start) |-> ##[1:40] (video_valid && video_index == '0))
    else $error("start gave no first read");
  AST_DONE_LAG: assert property (
    scan_done_pulse |-> last == IDX_W'(N - 1) && rises == 2'h2)
    else $error("scan done mistimed");
  AST_DONE_OFF: assert property (
    scan_done_pulse |-> $past(scan_done_enable, 3))
    else $error("scan done while disabled");
  AST_GATE_CLEAR: assert property (
    video_valid && $past(overflow_gate, 4)
    |-> video_sample == '0) else $error("charge under gate");
  AST_INTEG: assert property (
    $stable(overflow_gate) [*5] |-> integrating == !overflow_gate)
    else $error("integrating wrong");
  AST_GATE_FALL: assert property (
    $fell(overflow_gate) |-> ##[1:4] integrating)
    else $error("no integration after gate");
  AST_LINE_RESET: assert property (
    line_reset == (video_valid && $past(voltage_sense)))
    else $error("line reset wrong");
  cover property (scan_done_pulse);
  cover property (line_reset);
  cover property ($fell(overflow_gate));
endmodule
bind lasc_scan lasc_scan_chk #(.N(ELEMENTS), .IDX_W(IDX_W), .ACC_W(ACC_W))
  u_chk (.*);

//--- bench/lasc_drv.sv
/* phase clock and start generator facing lasc_scan.
   assumes clk is the bench clock; one start per go. */
`timescale 1ns/1ns
module lasc_drv #(
  parameter int unsigned H = 6
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic go,
  output logic      phase_one,
  output logic      phase_two,
  output logic      scan_start
);
  int unsigned cnt;
  logic        pend;
  assign phase_two = ~phase_one;
  // 16 ns start in one phase-two high, one per go
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt        <= 0;
      phase_one  <= 1'b1;
      pend       <= 1'b0;
      scan_start <= 1'b0;
    end else begin
      cnt <= (cnt == H - 1) ? 0 : cnt + 1;
      if (cnt == H - 1)
        phase_one <= ~phase_one;
      if (go)
        pend <= 1'b1;
      if (pend && phase_two && cnt == 0) begin
        scan_start <= 1'b1;
        pend       <= 1'b0;
      end else if (cnt == 4)
        scan_start <= 1'b0;
    end
  end
endmodule

//--- bench/lasc_scan_test.sv
/* self-checking bench for lasc_scan, 8 elements.
   assumes lasc_drv drives phase clocks and start. */
`timescale 1ns/1ns
module lasc_scan_test;
  import lasc_pkg::*;
  localparam int unsigned N = 8;
  typedef struct packed {
    logic en, g, vs;
    logic [7:0] lv, ed, ez, el;
  } lasc_row_t;
  lasc_row_t rows [3] = '{'{1'h1, 1'h0, 1'h0, 8'h0A, 8'h01, 8'h00, 8'h00},
    '{1'h0, 1'h0, 1'h1, 8'hC8, 8'h00, 8'h00, 8'h08},
    '{1'h1, 1'h1, 1'h1, 8'hFF, 8'h01, 8'h08, 8'h08}};
  logic clk = 1'b0, reset_n = 1'b0, go = 1'b0, overflow_gate = 1'b0;
  logic scan_done_enable = 1'b0, voltage_sense = 1'b0;
  logic [7:0] light_level = 8'h00;
  logic phase_one, phase_two, scan_start, video_valid, line_reset;
  logic scan_done_pulse, integrating;
  logic [2:0] light_index, video_index;
  logic [15:0] video_sample;
  int errors = 0, cmp_count = 0, nv = 0, nd = 0, nl = 0, nz = 0;
  always #2 clk = ~clk;
  lasc_drv drv (.*);
  lasc_scan #(.ELEMENTS(N)) dut (.*);
  task automatic summarize();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(negedge clk) begin
    if (video_valid === 1'b1) begin
      chk(16'(video_index), 16'(nv));
      nv++;
      nz += int'(video_sample === 16'h0000);
      nl += int'(line_reset === 1'b1);
    end
    nd += int'(scan_done_pulse === 1'b1);
  end
  task automatic run(input lasc_row_t r);
    int k;
    {nv, nd, nz, nl, k} = '0;
    overflow_gate    <= r.g;
    scan_done_enable <= r.en;
    voltage_sense    <= r.vs;
    light_level      <= r.lv;
    // one start per row sets exposure
    go               <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (nv < N && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (k == 400) begin
      errors++;
      summarize();
    end
    // done is two phase periods after the last read; 40 clk covers it
    repeat (40) @(posedge clk);
    chk(16'(nd), 16'(r.ed));
    chk(16'(nz), 16'(r.ez));
    chk(16'(nl), 16'(r.el));
    chk(16'(integrating), 16'(!r.g));
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 3; i++)
      run(rows[i]);
    nv = 0;
    overflow_gate <= 1'b0;
    repeat (60) @(posedge clk);
    chk(16'(nv), 16'h0000);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (50) @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    chk(16'({video_valid, scan_done_pulse, integrating}), 16'h0000);
    reset_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(16'(light_index), 16'h0001);
    @(posedge clk);
    run(rows[0]);
    summarize();
  end
endmodule
